// ---- sleep_clock_gating_ctrl.sv ----
// Contract
// - mode 111 with crystal enters extended standby
// - extended standby wakes after six clocks
// - per mode clock domains and main source
// - per mode accepted wake sources
// - deep modes: line c or level a/b
// - timer oscillator and async need async select
// - standby modes require external crystal
// - converter stays on; reenable flags extended conversion
// - comparator off in power-down, save and standby modes; reference kept
// - brownout detector active when fuse programmed
// - enabled watchdog never gated by sleep
// - reference on while brownout detector, converter or comparator on its reference is enabled
// - input buffers off when io and converter stopped
// - debug fuse keeps main source in down/save
// - disable bit or unprogrammed fuse disables scan port
// - tdo undriven when scan port not shifting
// - mode code map, 100 and 101 reserved
// - sleep only while arm bit set
// - halt four cycles past startup after wake
// sleep and clock-domain controller with an AXI4-Lite register slave
// assumes mclk is the free running main clock; wake and tap inputs are asynchronous
`timescale 1ns/100ps
`include "sleep_ctrl_map.svh"
module sleep_clock_gating_ctrl
   import sleep_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // axi4-lite write address, data and response
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // core sleep request
   input  wire logic        sleep_req,
   output logic             core_halted,
   // wake sources (asynchronous)
   input  wire logic        ext_irq_line_a,
   input  wire logic        ext_irq_line_b,
   input  wire logic        ext_irq_line_c,
   input  wire logic        irq_ab_level_mode,
   input  wire logic        two_wire_port_match,
   input  wire logic        timer2_wake,
   input  wire logic        self_program_op_ready,
   input  wire logic        adc_wake,
   input  wire logic        other_io_wake,
   // gated domain clocks
   output logic             core_clock_domain,
   output logic             progmem_clock_domain,
   output logic             io_clock_domain,
   output logic             converter_clock_domain,
   output logic             async_clock_domain,
   // oscillator and analog enables
   output logic             main_osc_en,
   output logic             timer_osc_en,
   output logic             adc_power_en,
   output logic             adc_extended_conv,
   output logic             acmp_en,
   output logic             vref_en,
   output logic             bod_en,
   output logic             wdt_en,
   output logic             input_buf_en,
   output logic             wake_input_buf_en,
   // scan port
   output logic             scan_port_en,
   input  wire logic        tap_shifting,
   input  wire logic        tap_tdo_data,
   output logic             tdo_out,
   output logic             tdo_oe_n
);
   typedef struct packed
   {
      logic [31:0] ctrl;
      logic [31:0] fuse;
      logic        aw_got;
      logic [7:0]  aw_addr;
      logic        w_got;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      pwr_state_t  state;
      sleep_mode_t mode;
      logic [3:0]  cnt;
      logic        adc_was_off;
      logic        ext_conv;
      logic [8:0]  sync1;
      logic [8:0]  sync2;
      logic        tap_s1;
      logic        tap_s2;
      logic        en_io;
      logic        en_adc;
      logic        en_asy;
      logic        en_core;
   } state_t;

   state_t st_reg;
   state_t st_next;

   logic       as2;
   logic       xtal;
   logic       adc_on;
   logic       in_sleep;
   logic       deep;
   logic       ext_ok;
   logic       wake_hit;
   logic       wr_fire;
   logic [31:0] wr_merged;
   logic [31:0] rd_val;
   logic       rd_ok;
   logic       bad_mode;
   logic       mode_io;
   logic       mode_adc;
   logic       mode_asy;
   logic       mode_main;
   sleep_mode_t tbl_mode;
   logic       scan_on;
   logic [8:0] w;

   assign as2    = st_reg.ctrl[`CTRL_AS2_BIT];
   assign xtal   = st_reg.ctrl[`CTRL_XTAL_BIT];
   assign adc_on = st_reg.ctrl[`CTRL_ADC_BIT];
   assign w      = st_reg.sync2;
   assign in_sleep = (st_reg.state == ST_SLEEP);
   assign deep   = (st_reg.mode != MODE_IDLE);

   // per-mode domain table: requested mode while running, so entry gates follow it, else the latched one
   assign tbl_mode = (st_reg.state == ST_RUN) ? sleep_mode_t'(st_reg.ctrl[2:0]) : st_reg.mode;
   always_comb
   begin
      mode_io   = 1'b0;
      mode_adc  = 1'b0;
      mode_asy  = 1'b0;
      mode_main = 1'b0;
      unique case (tbl_mode)
         MODE_IDLE:  begin mode_io = 1'b1; mode_adc = 1'b1; mode_asy = 1'b1; mode_main = 1'b1; end
         MODE_ADCNR: begin mode_adc = 1'b1; mode_asy = 1'b1; mode_main = 1'b1; end
         MODE_PDOWN: ;
         MODE_PSAVE: mode_asy = as2;
         MODE_STBY:  mode_main = 1'b1;
         MODE_XSTBY:
         begin
            mode_asy  = as2;
            mode_main = 1'b1;
         end
         default: ;
      endcase
   end

   // wake decode: w = {other,adc,spm,t2,twi,c,b,a,lvl}
   always_comb
   begin
      ext_ok = w[3] | ((w[1] | w[2]) & (w[0] | !deep));
      wake_hit = ext_ok | w[4];
      unique case (st_reg.mode)
         MODE_IDLE:  wake_hit = wake_hit | w[5] | w[6] | w[7] | w[8];
         MODE_ADCNR: wake_hit = wake_hit | w[5] | w[6] | w[7];
         MODE_PSAVE, MODE_XSTBY: wake_hit = wake_hit | (w[5] & as2);
         default: ;
      endcase
   end

   assign bad_mode = (st_reg.ctrl[2:0] == 3'b100) || (st_reg.ctrl[2:0] == 3'b101)
                     || ((st_reg.ctrl[2:0] == 3'b110 || st_reg.ctrl[2:0] == 3'b111) && !xtal);
   assign scan_on = st_reg.fuse[`FUSE_JTAG_BIT] & !st_reg.ctrl[`CTRL_JTD_BIT];

   // register write merge and read mux
   assign wr_fire = st_reg.aw_got & st_reg.w_got & !st_reg.bvalid;
   always_comb
   begin
      wr_merged = st_reg.ctrl;
      for (int i = 0; i < 4; i++)
         if (st_reg.w_strb[i])
            wr_merged[i*8 +: 8] = st_reg.w_data[i*8 +: 8];
   end

   always_comb
   begin
      rd_ok  = 1'b1;
      rd_val = 32'h0000_0000;
      unique case (s_axi_araddr)
         `REG_CTRL:   rd_val = {21'h0, st_reg.ctrl[10:0]};
         `REG_FUSE:   rd_val = {29'h0, st_reg.fuse[2:0]};
         `REG_STATUS: rd_val = {23'h0, st_reg.ext_conv, st_reg.mode, st_reg.state, scan_on, 1'b0, bad_mode};
         `REG_CMD:    rd_val = 32'h0000_0000;
         default:     rd_ok  = 1'b0;
      endcase
   end

   always_comb
   begin
      st_next = st_reg;
      st_next.sync1 = {other_io_wake, adc_wake, self_program_op_ready, timer2_wake, two_wire_port_match,
                       ext_irq_line_c, ext_irq_line_b, ext_irq_line_a, irq_ab_level_mode};
      st_next.sync2 = st_reg.sync1;
      st_next.tap_s1 = tap_shifting;
      st_next.tap_s2 = st_reg.tap_s1;

      // axi write: address and data taken in either order
      if (s_axi_awvalid && !st_reg.aw_got)
      begin
         st_next.aw_got  = 1'b1;
         st_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_reg.w_got)
      begin
         st_next.w_got  = 1'b1;
         st_next.w_data = s_axi_wdata;
         st_next.w_strb = s_axi_wstrb;
      end
      if (wr_fire)
      begin
         st_next.aw_got = 1'b0;
         st_next.w_got  = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp  = `RESP_OKAY;
         unique case (st_reg.aw_addr)
            `REG_CTRL:   st_next.ctrl = {21'h0, wr_merged[10:0]};
            `REG_FUSE:   st_next.fuse = {29'h0, st_reg.w_data[2:0]};
            `REG_STATUS: ;
            `REG_CMD:    ;
            default:     st_next.bresp = `RESP_SLVERR;
         endcase
      end
      if (st_reg.bvalid && s_axi_bready)
         st_next.bvalid = 1'b0;

      if (s_axi_arvalid && !st_reg.rvalid)
      begin
         st_next.rvalid = 1'b1;
         st_next.rdata  = rd_val;
         st_next.rresp  = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (st_reg.rvalid && s_axi_rready)
         st_next.rvalid = 1'b0;

      // converter off then on: next conversion is extended; a re-enable beats a clear in the same cycle
      if (wr_fire && st_reg.aw_addr == `REG_CMD && st_reg.w_data[1])
         st_next.ext_conv = 1'b0;
      if (!adc_on)
         st_next.adc_was_off = 1'b1;
      else if (st_reg.adc_was_off)
      begin
         st_next.adc_was_off = 1'b0;
         st_next.ext_conv    = 1'b1;
      end

      unique case (st_reg.state)
         ST_RUN:
         begin
            st_next.cnt = 4'h0;
            if (sleep_req && st_reg.ctrl[`CTRL_ARM_BIT] && !bad_mode)
            begin
               st_next.state = ST_SLEEP;
               st_next.mode  = sleep_mode_t'(st_reg.ctrl[2:0]);
            end
         end
         ST_SLEEP:
            if (wake_hit)
               st_next.state = ST_WAKE;
         ST_WAKE:
         begin
            st_next.cnt = st_reg.cnt + 4'h1;
            // main source kept: six-clock wake; else full startup
            if (mode_main ? (st_reg.cnt == `WAKE_FAST_CYC - 4'h1)
                          : (st_reg.cnt == `STARTUP_CYC - 4'h1))
            begin
               st_next.state = ST_HALT;
               st_next.cnt   = 4'h0;
            end
         end
         ST_HALT:
         begin
            st_next.cnt = st_reg.cnt + 4'h1;
            if (st_reg.cnt == `HALT_EXTRA_CYC - 4'h1)
               st_next.state = ST_RUN;
         end
      endcase

      // gate enables: io, converter and async domains come back once wake starts; core domains only on return to run
      st_next.en_core = (st_next.state == ST_RUN);
      st_next.en_io   = (st_next.state != ST_SLEEP) | mode_io;
      st_next.en_adc  = (st_next.state != ST_SLEEP) | mode_adc;
      st_next.en_asy  = ((st_next.state != ST_SLEEP) | mode_asy) & as2;
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_reg       <= '0;
         st_reg.ctrl  <= `CTRL_RESET;
         st_reg.fuse  <= `FUSE_RESET;
         st_reg.state <= ST_RUN;
         st_reg.mode  <= MODE_IDLE;
         st_reg.en_core <= 1'b1;
         st_reg.en_io   <= 1'b1;
         st_reg.en_adc  <= 1'b1;
      end
      else
         st_reg <= st_next;
   end

   // glitch-free gates, one per domain
   clock_gate_cell u_gate_core (.clk_in(mclk), .rstn(rstn), .enable(st_reg.en_core), .clk_out(core_clock_domain));
   clock_gate_cell u_gate_prog (.clk_in(mclk), .rstn(rstn), .enable(st_reg.en_core), .clk_out(progmem_clock_domain));
   clock_gate_cell u_gate_io   (.clk_in(mclk), .rstn(rstn), .enable(st_reg.en_io),   .clk_out(io_clock_domain));
   clock_gate_cell u_gate_adc  (.clk_in(mclk), .rstn(rstn), .enable(st_reg.en_adc),  .clk_out(converter_clock_domain));
   clock_gate_cell u_gate_asy  (.clk_in(mclk), .rstn(rstn), .enable(st_reg.en_asy),  .clk_out(async_clock_domain));

   assign core_halted  = (st_reg.state != ST_RUN);
   assign main_osc_en  = !in_sleep | mode_main
                         | (st_reg.fuse[`FUSE_DBG_BIT]
                            & (st_reg.mode == MODE_PDOWN || st_reg.mode == MODE_PSAVE));
   assign timer_osc_en = as2 & (!in_sleep || (st_reg.mode != MODE_PDOWN && st_reg.mode != MODE_STBY));
   assign adc_power_en = adc_on;
   assign adc_extended_conv = st_reg.ext_conv;
   assign acmp_en = st_reg.ctrl[`CTRL_ACMP_BIT]
                    & (!in_sleep | st_reg.mode == MODE_IDLE | st_reg.mode == MODE_ADCNR);
   assign bod_en  = st_reg.fuse[`FUSE_BOD_BIT];
   assign wdt_en  = st_reg.ctrl[`CTRL_WDT_BIT];
   // comparator on its reference holds the reference even when gated off
   assign vref_en = bod_en | adc_on
                    | (st_reg.ctrl[`CTRL_ACMP_BIT] & st_reg.ctrl[`CTRL_ACREF_BIT]);
   assign input_buf_en = !(in_sleep & !mode_io & !mode_adc);
   assign wake_input_buf_en = 1'b1;
   assign scan_port_en = scan_on;
   assign tdo_out  = tap_tdo_data;
   assign tdo_oe_n = !(scan_on & st_reg.tap_s2);

   assign s_axi_awready = !st_reg.aw_got;
   assign s_axi_wready  = !st_reg.w_got;
   assign s_axi_bvalid  = st_reg.bvalid;
   assign s_axi_bresp   = st_reg.bresp;
   assign s_axi_arready = !st_reg.rvalid;
   assign s_axi_rvalid  = st_reg.rvalid;
   assign s_axi_rdata   = st_reg.rdata;
   assign s_axi_rresp   = st_reg.rresp;

   // assertions
   sequence s_wake_fast;
      (st_reg.state == ST_WAKE) && mode_main && st_reg.cnt == 4'h0;
   endsequence
   property p_six_cycles;
      @(posedge mclk) disable iff (!rstn)
         $rose(st_reg.state == ST_WAKE) ##0 s_wake_fast |-> ##6 (st_reg.state == ST_HALT);
   endproperty
   wake_six_a: assert property (p_six_cycles) else $error("fast wake not six cycles");
   halt_four_a: assert property (@(posedge mclk) disable iff (!rstn)
      $rose(st_reg.state == ST_HALT) |-> (st_reg.state == ST_HALT) [*4] ##1 (st_reg.state == ST_RUN))
      else $error("halt not four cycles");
   arm_needed_a: assert property (@(posedge mclk) disable iff (!rstn)
      $rose(in_sleep) |-> $past(st_reg.ctrl[`CTRL_ARM_BIT])) else $error("sleep without arm");
   xtal_needed_a: assert property (@(posedge mclk) disable iff (!rstn)
      in_sleep && st_reg.mode[2] |-> xtal) else $error("standby without crystal");
   pdown_clocks_a: assert property (@(posedge mclk) disable iff (!rstn)
      in_sleep && st_reg.mode == MODE_PDOWN |-> !st_reg.en_io && !st_reg.en_adc && !st_reg.en_asy)
      else $error("power-down clocks running");
   xstby_osc_a: assert property (@(posedge mclk) disable iff (!rstn)
      in_sleep && st_reg.mode == MODE_XSTBY |-> main_osc_en) else $error("oscillator off");
   acmp_off_a: assert property (@(posedge mclk) disable iff (!rstn)
      in_sleep && st_reg.mode >= MODE_PDOWN |-> !acmp_en) else $error("comparator on in deep sleep");
   inbuf_off_a: assert property (@(posedge mclk) disable iff (!rstn)
      in_sleep && st_reg.mode == MODE_STBY |-> !input_buf_en) else $error("input buffers on");
   dbg_osc_a: assert property (@(posedge mclk) disable iff (!rstn)
      in_sleep && st_reg.mode == MODE_PDOWN && st_reg.fuse[`FUSE_DBG_BIT] |-> main_osc_en)
      else $error("debug clock dropped");
   tdo_float_a: assert property (@(posedge mclk) disable iff (!rstn)
      !st_reg.tap_s2 |-> tdo_oe_n) else $error("tdo driven while idle");
   vref_a: assert property (@(posedge mclk) disable iff (!rstn)
      vref_en == (bod_en | adc_on | (st_reg.ctrl[`CTRL_ACMP_BIT] & st_reg.ctrl[`CTRL_ACREF_BIT])))
      else $error("vref mismatch");
endmodule : sleep_clock_gating_ctrl

// ---- sleep_ctrl_map.svh ----
// register offsets, field positions and timing counts for the sleep clock controller
// assumes inclusion by the design module and the testbench
`ifndef SLEEP_CTRL_MAP_SVH
`define SLEEP_CTRL_MAP_SVH

`define REG_CTRL         8'h00
`define REG_FUSE         8'h04
`define REG_STATUS       8'h08
`define REG_CMD          8'h0C

`define CTRL_MODE_LSB    0
`define CTRL_ARM_BIT     3
`define CTRL_AS2_BIT     4
`define CTRL_XTAL_BIT    5
`define CTRL_ADC_BIT     6
`define CTRL_ACMP_BIT    7
`define CTRL_ACREF_BIT   8
`define CTRL_WDT_BIT     9
`define CTRL_JTD_BIT     10
`define CTRL_RESET       32'h0000_0000

`define FUSE_BOD_BIT     0
`define FUSE_DBG_BIT     1
`define FUSE_JTAG_BIT    2
`define FUSE_RESET       32'h0000_0000

`define CMD_SLEEP_BIT    0

`define WAKE_FAST_CYC    4'h6
`define HALT_EXTRA_CYC   4'h4
`define STARTUP_CYC      4'h8

`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// ---- sleep_ctrl_pkg.sv ----
// types shared by the sleep clock controller files
// assumes the map header is on the include path
package sleep_ctrl_pkg;
   typedef enum logic [2:0]
   {
      MODE_IDLE   = 3'h0,
      MODE_ADCNR  = 3'h1,
      MODE_PDOWN  = 3'h2,
      MODE_PSAVE  = 3'h3,
      MODE_STBY   = 3'h6,
      MODE_XSTBY  = 3'h7
   } sleep_mode_t;

   // gray order along run -> sleep -> wake -> halt
   typedef enum logic [1:0]
   {
      ST_RUN   = 2'b00,
      ST_SLEEP = 2'b01,
      ST_WAKE  = 2'b11,
      ST_HALT  = 2'b10
   } pwr_state_t;
endpackage : sleep_ctrl_pkg

// ---- clock_gate_cell.sv ----
// glitch-free clock gate: enable latched while the clock is low
// assumes clk_in is a free running domain clock
`timescale 1ns/100ps
module clock_gate_cell
(
   // clock
   input  wire logic clk_in,
   input  wire logic rstn,
   // control
   input  wire logic enable,
   output logic      clk_out
);
   logic en_latch;

   // enable changes only while the clock is low, so no pulse is cut short
   always_latch
   begin
      if (!rstn)
         en_latch <= 1'b0;
      else if (!clk_in)
         en_latch <= enable;
   end

   assign clk_out = clk_in & en_latch;
endmodule : clock_gate_cell

// ---- core_far_side.sv ----
// far-side model: the core issuing sleep instructions and the board pull-up on the scan data pin
// assumes the bench pulses exec_sleep for one clock while the core runs
`timescale 1ns/100ps
module core_far_side
(
   // clock and reset
   input  wire logic mclk,
   input  wire logic rstn,
   // core side
   input  wire logic exec_sleep,
   input  wire logic core_halted,
   output logic      sleep_req,
   // scan data pin
   input  wire logic tdo_out,
   input  wire logic tdo_oe_n,
   output logic      tdo_wire
);
   // a halted core executes nothing, so a request is only issued while running
   always_ff @(posedge mclk or negedge rstn)
      if (!rstn)
         sleep_req <= 1'b0;
      else
         sleep_req <= exec_sleep & ~core_halted;

   // board pull-up holds the pin whenever the device lets it float
   assign tdo_wire = tdo_oe_n ? 1'b1 : tdo_out;
endmodule : core_far_side

// ---- testbench.sv ----
// self-checking bench for the sleep clock controller
// assumes the design files and the core model are compiled first
`timescale 1ns/100ps
`include "sleep_ctrl_map.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
   $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module testbench
   import sleep_ctrl_pkg::*;
;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic [10:0] dom;
   logic mclk, rstn, exec_sleep, sleep_req, core_halted, tdo_wire;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic ext_irq_line_a, ext_irq_line_b, ext_irq_line_c, irq_ab_level_mode, two_wire_port_match;
   logic timer2_wake, self_program_op_ready, adc_wake, other_io_wake;
   logic core_clock_domain, progmem_clock_domain, io_clock_domain, converter_clock_domain;
   logic async_clock_domain, main_osc_en, timer_osc_en, adc_power_en, adc_extended_conv;
   logic acmp_en, vref_en, bod_en, wdt_en, input_buf_en, wake_input_buf_en;
   logic scan_port_en, tap_shifting, tap_tdo_data, tdo_out, tdo_oe_n;
   int   n_errors = 0;
   int   n_checks = 0;

   sleep_clock_gating_ctrl DUT
   (
      .mclk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .sleep_req, .core_halted, .ext_irq_line_a, .ext_irq_line_b, .ext_irq_line_c,
      .irq_ab_level_mode, .two_wire_port_match, .timer2_wake, .self_program_op_ready, .adc_wake,
      .other_io_wake, .core_clock_domain, .progmem_clock_domain, .io_clock_domain,
      .converter_clock_domain, .async_clock_domain, .main_osc_en, .timer_osc_en, .adc_power_en,
      .adc_extended_conv, .acmp_en, .vref_en, .bod_en, .wdt_en, .input_buf_en,
      .wake_input_buf_en, .scan_port_en, .tap_shifting, .tap_tdo_data, .tdo_out, .tdo_oe_n
   );

   core_far_side far
   (
      .mclk, .rstn, .exec_sleep, .core_halted, .sleep_req, .tdo_out, .tdo_oe_n, .tdo_wire
   );

   assign dom = {core_clock_domain, progmem_clock_domain, io_clock_domain, converter_clock_domain,
                 async_clock_domain, main_osc_en, timer_osc_en, input_buf_en, acmp_en, adc_power_en, wdt_en};

   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task automatic finish_test();
      if (n_errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test

   task automatic step();
      @(posedge mclk);
      #1;
   endtask : step

   // one bus transfer; payload held until each channel is taken
   task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d);
      bit ta, tw, tr;
      @(posedge mclk);
      s_axi_awaddr  <= a;
      s_axi_araddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= wr;
      s_axi_wvalid  <= wr;
      s_axi_bready  <= wr;
      s_axi_arvalid <= !wr;
      s_axi_rready  <= !wr;
      for (int i = 0; i < 40; i++)
      begin
         @(negedge mclk);
         ta   = (s_axi_awvalid & s_axi_awready) | (s_axi_arvalid & s_axi_arready);
         tw   = s_axi_wvalid & s_axi_wready;
         tr   = wr ? s_axi_bvalid : s_axi_rvalid;
         resp = wr ? s_axi_bresp : s_axi_rresp;
         rd   = s_axi_rdata;
         @(posedge mclk);
         if (ta)
         begin
            s_axi_awvalid <= 1'b0;
            s_axi_arvalid <= 1'b0;
         end
         if (tw)
            s_axi_wvalid <= 1'b0;
         if (tr)
         begin
            s_axi_bready <= 1'b0;
            s_axi_rready <= 1'b0;
            return;
         end
      end
      n_errors++;
      finish_test();
   endtask : axi

   task automatic enter(input logic [31:0] ctrl, input bit ok);
      axi(1'b1, `REG_CTRL, ctrl);
      @(posedge mclk);
      exec_sleep <= 1'b1;
      @(posedge mclk);
      exec_sleep <= 1'b0;
      for (int i = 0; i < 8 && core_halted !== 1'b1; i++)
         step();
      `CHK(core_halted, ok)
   endtask : enter

   // src order: level mode, line a, line b, line c, address match, timer, self-program, adc, other io
   task automatic wake(input logic [8:0] src, input bit ok, output int cyc);
      @(posedge mclk);
      {irq_ab_level_mode, ext_irq_line_a, ext_irq_line_b, ext_irq_line_c, two_wire_port_match,
       timer2_wake, self_program_op_ready, adc_wake, other_io_wake} <= src;
      for (cyc = 0; cyc < 30 && core_halted === 1'b1; cyc++)
         step();
      `CHK(core_halted, !ok)
      @(posedge mclk);
      {irq_ab_level_mode, ext_irq_line_a, ext_irq_line_b, ext_irq_line_c, two_wire_port_match,
       timer2_wake, self_program_op_ready, adc_wake, other_io_wake} <= 9'h000;
   endtask : wake

   function automatic logic [10:0] exp_dom(input logic [2:0] m, input bit as2, input bit dbg);
      bit io, cv;
      io = (m == MODE_IDLE);
      cv = io | (m == MODE_ADCNR);
      return {2'b00, io, cv, as2 & (cv | m[0]), cv | m[2] | dbg, as2 & (cv | m[0]), cv, cv, 2'b11};
   endfunction : exp_dom

   task automatic chk_dom(input logic [10:0] e);
      repeat (2) @(posedge mclk);
      #5;
      `CHK(dom, e)
      `CHK(wake_input_buf_en, 1'b1)
   endtask : chk_dom

   task automatic regs_test();
      axi(1'b0, `REG_CTRL, 32'h0000_0000);
      `CHK(rd, `CTRL_RESET)
      axi(1'b0, `REG_FUSE, 32'h0000_0000);
      `CHK(rd, `FUSE_RESET)
      axi(1'b1, `REG_CTRL, 32'h0000_07FF);
      axi(1'b0, `REG_CTRL, 32'h0000_0000);
      `CHK(rd, 32'h0000_07FF)
      axi(1'b0, 8'h10, 32'h0000_0000);
      `CHK(resp, `RESP_SLVERR)
      axi(1'b1, 8'h10, 32'h0000_0001);
      `CHK(resp, `RESP_SLVERR)
      axi(1'b0, `REG_STATUS, 32'h0000_0000);
      `CHK(resp, `RESP_OKAY)
      axi(1'b1, `REG_CTRL, 32'h0000_0000);
   endtask : regs_test

   task automatic sweep_test();
      sleep_mode_t ml [6] = '{MODE_IDLE, MODE_ADCNR, MODE_PDOWN, MODE_PSAVE, MODE_STBY, MODE_XSTBY};
      int c [6];
      // watchdog, comparator, converter, crystal, async select and arm all set
      foreach (ml[k])
      begin
         enter(32'h0000_02F8 | ml[k], 1'b1);
         chk_dom(exp_dom(ml[k], 1'b1, 1'b0));
         wake(9'h020, 1'b1, c[k]);
      end
      `CHK(c[2] - c[5], 2)
      `CHK(c[4], c[5])
      enter(32'h0000_02E8 | MODE_PSAVE, 1'b1);
      chk_dom(exp_dom(MODE_PSAVE, 1'b0, 1'b0));
      wake(9'h008, 1'b0, c[0]);
      wake(9'h020, 1'b1, c[0]);
   endtask : sweep_test

   task automatic wake_test();
      logic [8:0] rej [5] = '{9'h001, 9'h002, 9'h004, 9'h080, 9'h008};
      int c;
      enter(32'h0000_02F8 | MODE_PDOWN, 1'b1);
      foreach (rej[k])
         wake(rej[k], 1'b0, c);
      wake(9'h180, 1'b1, c);
      enter(32'h0000_02F8 | MODE_PDOWN, 1'b1);
      wake(9'h010, 1'b1, c);
      enter(32'h0000_02F8 | MODE_ADCNR, 1'b1);
      wake(9'h001, 1'b0, c);
      wake(9'h002, 1'b1, c);
      enter(32'h0000_02F8 | MODE_IDLE, 1'b1);
      wake(9'h001, 1'b1, c);
      enter(32'h0000_02F8 | MODE_IDLE, 1'b1);
      wake(9'h080, 1'b1, c);
      enter(32'h0000_02F8 | MODE_PSAVE, 1'b1);
      wake(9'h008, 1'b1, c);
   endtask : wake_test

   task automatic refuse_test();
      enter(32'h0000_02F0, 1'b0);
      enter(32'h0000_02FC, 1'b0);
      enter(32'h0000_02FD, 1'b0);
      enter(32'h0000_02D8 | MODE_STBY, 1'b0);
      enter(32'h0000_02D8 | MODE_XSTBY, 1'b0);
   endtask : refuse_test

   task automatic analog_test();
      int c;
      axi(1'b1, `REG_FUSE, 32'h0000_0001);
      axi(1'b1, `REG_CTRL, 32'h0000_0000);
      step();
      `CHK({bod_en, vref_en}, 2'b11)
      enter(32'h0000_022A, 1'b1);
      step();
      `CHK({bod_en, wdt_en, vref_en}, 3'b111)
      wake(9'h020, 1'b1, c);
      axi(1'b1, `REG_FUSE, 32'h0000_0000);
      axi(1'b1, `REG_CTRL, 32'h0000_0000);
      step();
      `CHK({bod_en, vref_en}, 2'b00)
      // comparator on the internal reference, power-down
      enter(32'h0000_01AA, 1'b1);
      step();
      `CHK({acmp_en, vref_en}, 2'b01)
      wake(9'h020, 1'b1, c);
      axi(1'b1, `REG_CTRL, 32'h0000_0040);
      axi(1'b1, `REG_CMD, 32'h0000_0002);
      step();
      `CHK(adc_extended_conv, 1'b0)
      axi(1'b1, `REG_CTRL, 32'h0000_0000);
      axi(1'b1, `REG_CTRL, 32'h0000_0040);
      step();
      `CHK({adc_power_en, adc_extended_conv, vref_en}, 3'b111)
      axi(1'b1, `REG_CMD, 32'h0000_0002);
      step();
      `CHK(adc_extended_conv, 1'b0)
      axi(1'b1, `REG_FUSE, 32'h0000_0002);
      enter(32'h0000_02F8 | MODE_PDOWN, 1'b1);
      chk_dom(exp_dom(MODE_PDOWN, 1'b1, 1'b1));
      wake(9'h020, 1'b1, c);
   endtask : analog_test

   task automatic scan_test();
      axi(1'b1, `REG_CTRL, 32'h0000_0000);
      axi(1'b1, `REG_FUSE, 32'h0000_0004);
      step();
      `CHK({scan_port_en, tdo_oe_n, tdo_wire}, 3'b111)
      @(posedge mclk);
      tap_shifting <= 1'b1;
      repeat (4) step();
      `CHK({tdo_oe_n, tdo_wire}, 2'b00)
      axi(1'b1, `REG_CTRL, 32'h0000_0400);
      step();
      `CHK({scan_port_en, tdo_oe_n, tdo_wire}, 3'b011)
      axi(1'b1, `REG_CTRL, 32'h0000_0000);
      axi(1'b1, `REG_FUSE, 32'h0000_0000);
      step();
      `CHK(scan_port_en, 1'b0)
   endtask : scan_test

   initial
   begin
      {rstn, exec_sleep, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready, ext_irq_line_a, ext_irq_line_b, ext_irq_line_c} = '0;
      {irq_ab_level_mode, two_wire_port_match, timer2_wake, self_program_op_ready, adc_wake} = '0;
      {other_io_wake, tap_shifting, tap_tdo_data} = '0;
      s_axi_wstrb = 4'hF;
      repeat (8) @(posedge mclk);
      rstn <= 1'b1;
      regs_test();
      sweep_test();
      wake_test();
      refuse_test();
      analog_test();
      scan_test();
      finish_test();
   end
endmodule : testbench
